// ### hw/tpa_acq.sv
// Triggered peak acquisition: cycle timer, trigger gating, peak search
// Assumes video samples arrive in order with first/last marks, 12-bit dark-corrected
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Measure only after a valid trigger event
// - Averaging skips pre-trigger values, uses earlier triggered
// - Trigger time difference from cycle start
// - Trigger time difference output three cycles later
// - Exposure ends 100 ns after cycle start
// - Counter counts outputs; counter, stamps clear separately
// - Range of interest in percent, default 0-100
// - Peak accepted only wholly inside range
// - Primary exposure limited to 3..10000 us
// - Second exposure must be below primary
// - Regulated mode adjusts exposure, at most seven steps in a row, then one cycle without a step
// - Manual mode holds exposure unchanged
// - Alternating mode swaps exposures every cycle
// - Alternating mode bypasses video averaging
// - Automatic mode picks better exposure per measurement
// - Dip reaching modulation depth splits peaks
// - Peak modulation default 50 percent
// - Unsplit peak reports centre of gravity
// - Only samples above threshold, default 2 percent
module tpa_acq #(
    parameter int PIX_W = 10,
    parameter int VID_W = 12
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               trig_in,
    input  wire logic               vid_valid,
    input  wire logic [VID_W-1:0]   vid_data,
    input  wire logic               vid_first,
    input  wire logic               vid_last,
    output logic                    cycle_start,
    output logic                    expo_end,
    output logic [13:0]             expo_time,
    output logic                    meas_valid,
    output logic [31:0]             meas_pos,
    output logic [31:0]             meas_cnt,
    output logic                    avg_bypass,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    import tpa_pkg::*;

    localparam int NPIX = 1 << PIX_W;

    // Control registers
    logic [1:0]       mode_r;
    logic             trig_en_r;
    logic [31:0]      period_r;
    logic [13:0]      exp1_r, exp2_r;
    logic [6:0]       roi_s_r, roi_e_r, mod_r, thr_r;
    logic [3:0]       bad_cfg_r;

    // AXI write channel state
    logic             aw_got_r, w_got_r;
    logic [7:0]       aw_r;
    logic [31:0]      wd_r;
    logic [3:0]       ws_r;
    logic             wr_go;
    logic [31:0]      wval;
    assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
    always_comb begin
        wval = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            if (ws_r[i]) begin
                wval[8*i +: 8] = wd_r[8*i +: 8];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            aw_r          <= 8'h00;
            wd_r          <= 32'h0000_0000;
            ws_r          <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= !aw_got_r && !s_axi_awready;
            s_axi_wready  <= !w_got_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wd_r    <= s_axi_wdata;
                ws_r    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_r[7:2] > ADDR_EXPCUR[7:2]) ? 2'h2 : 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes; out-of-range exposures are refused and flagged
    logic cnt_clr, ts_clr;
    assign cnt_clr = wr_go && aw_r == ADDR_CTRL && ws_r[0] && wd_r[CTRL_CNTCLR];
    assign ts_clr  = wr_go && aw_r == ADDR_CTRL && ws_r[0] && wd_r[CTRL_TSCLR];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r    <= MODE_MAN;
            trig_en_r <= 1'b0;
            period_r  <= PERIOD_RST;
            exp1_r    <= EXP1_RST;
            exp2_r    <= EXP2_RST;
            roi_s_r   <= ROI_START_RST;
            roi_e_r   <= ROI_END_RST;
            mod_r     <= MOD_RST;
            thr_r     <= THR_RST;
            bad_cfg_r <= 4'h0;
        end else if (wr_go) begin
            if (aw_r == ADDR_CTRL) begin
                mode_r    <= wval[CTRL_MODE_LSB +: 2];
                trig_en_r <= wval[CTRL_TRIGEN];
            end else if (aw_r == ADDR_PERIOD) begin
                period_r  <= (wval < 32'h0000_0002) ? 32'h0000_0002 : wval;
            end else if (aw_r == ADDR_EXP1) begin
                if (wval >= 32'(EXP_MIN_US) && wval <= 32'(EXP_MAX_US) && wval > {18'h0, exp2_r}) begin
                    exp1_r <= wval[13:0];
                end else begin
                    bad_cfg_r[0] <= 1'b1;
                end
            end else if (aw_r == ADDR_EXP2) begin
                if (wval < {18'h0, exp1_r} && wval >= 32'(EXP_MIN_US)) begin
                    exp2_r <= wval[13:0];
                end else begin
                    bad_cfg_r[1] <= 1'b1;
                end
            end else if (aw_r == ADDR_ROI) begin
                if (wval[6:0] < wval[14:8] && wval[14:8] <= PCT_FULL) begin
                    roi_s_r <= wval[6:0];
                    roi_e_r <= wval[14:8];
                end else begin
                    bad_cfg_r[2] <= 1'b1;
                end
            end else if (aw_r == ADDR_THR) begin
                thr_r <= (wval[6:0] > PCT_FULL) ? PCT_FULL : wval[6:0];
                mod_r <= (wval[14:8] > PCT_FULL) ? PCT_FULL : wval[14:8];
            end else if (aw_r == ADDR_STAT) begin
                bad_cfg_r <= bad_cfg_r & ~wval[3:0];
            end
        end
    end

    // Trigger input: three flops, edge counted when stages 2 and 3 agree
    logic [2:0] trig_sy_r;
    logic       trig_lvl_r;
    logic       trig_ev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_sy_r  <= 3'h0;
            trig_lvl_r <= 1'b0;
        end else begin
            trig_sy_r <= {trig_sy_r[1:0], trig_in};
            if (trig_sy_r[1] == trig_sy_r[2]) begin
                trig_lvl_r <= trig_sy_r[2];
            end
        end
    end
    assign trig_ev = (trig_sy_r[1] == trig_sy_r[2]) && trig_sy_r[2] && !trig_lvl_r;

    // Cycle timer and trigger time stamp
    logic [31:0] cyc_cnt_r, ttd_cur_r, tstamp_r;
    logic        trig_pend_r, cyc_trig_r;
    logic [31:0] ttd_pipe_r [TTD_LAT];
    logic [TTD_LAT-1:0] ttd_v_r;
    logic        cyc_end;
    assign cyc_end = cyc_cnt_r >= period_r - 32'h0000_0001;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_cnt_r   <= 32'h0000_0000;
            cycle_start <= 1'b0;
            expo_end    <= 1'b0;
        end else begin
            cyc_cnt_r   <= cyc_end ? 32'h0000_0000 : cyc_cnt_r + 32'h0000_0001;
            cycle_start <= cyc_end;
            expo_end    <= cyc_cnt_r == 32'(EXP_END_CYC - 1);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_pend_r <= 1'b0;
            cyc_trig_r  <= 1'b0;
            ttd_cur_r   <= 32'h0000_0000;
            tstamp_r    <= 32'h0000_0000;
            ttd_v_r     <= '0;
            for (int i = 0; i < TTD_LAT; i++) begin
                ttd_pipe_r[i] <= 32'h0000_0000;
            end
        end else begin
            tstamp_r <= ts_clr ? 32'h0000_0000 : tstamp_r + 32'h0000_0001;
            if (trig_ev && !trig_pend_r) begin
                trig_pend_r <= 1'b1;
                ttd_cur_r   <= cyc_cnt_r;
            end
            if (cyc_end) begin
                cyc_trig_r  <= trig_pend_r || !trig_en_r;
                trig_pend_r <= trig_ev;
                if (trig_ev) begin
                    ttd_cur_r <= cyc_cnt_r;
                end
                ttd_pipe_r[0] <= ttd_cur_r;
                ttd_v_r[0]    <= trig_pend_r;
                for (int i = 1; i < TTD_LAT; i++) begin
                    ttd_pipe_r[i] <= ttd_pipe_r[i-1];
                    ttd_v_r[i]    <= ttd_v_r[i-1];
                end
            end
        end
    end

    // Exposure control per cycle
    logic [2:0]  settle_r;
    logic        alt_sel_r;
    logic [VID_W-1:0] last_max_r, line_max_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            expo_time  <= EXP1_RST;
            alt_sel_r  <= 1'b0;
            settle_r   <= 3'h0;
            avg_bypass <= 1'b0;
        end else begin
            avg_bypass <= mode_r == MODE_ALT;
            if (cyc_end) begin
                case (mode_r)
                    MODE_MAN: expo_time <= exp1_r;
                    MODE_ALT: begin
                        alt_sel_r <= !alt_sel_r;
                        expo_time <= alt_sel_r ? exp1_r : exp2_r;
                    end
                    MODE_AUTO: begin
                        expo_time <= last_max_r[VID_W-1] ? exp2_r : exp1_r;
                    end
                    default: begin
                        // Halve or double toward mid scale, bounded steps
                        if (settle_r != 3'(SETTLE_MAX) && last_max_r[VID_W-1]) begin
                            expo_time <= (expo_time >> 1) < 14'(EXP_MIN_US) ? 14'(EXP_MIN_US) : expo_time >> 1;
                            settle_r  <= settle_r + 3'h1;
                        end else if (settle_r != 3'(SETTLE_MAX) && !last_max_r[VID_W-2]) begin
                            expo_time <= (expo_time > 14'(EXP_MAX_US / 2)) ? 14'(EXP_MAX_US) : expo_time << 1;
                            settle_r  <= settle_r + 3'h1;
                        end else begin
                            settle_r  <= 3'h0;
                        end
                    end
                endcase
            end
        end
    end

    // Peak search over one video line
    tpa_pk_t          pk_st_r;
    logic [PIX_W-1:0] pix_r, lo_r, hi_r, pix_idx;
    logic [VID_W-1:0] pk_max_r, dip_r, thr_lvl;
    logic [47:0]      sum_w_r;
    logic [31:0]      sum_r;
    logic             above, in_roi, split;
    assign thr_lvl = VID_W'((32'(thr_r) << VID_W) / 32'(PCT_FULL));
    assign lo_r    = PIX_W'((32'(roi_s_r) * NPIX) / 32'(PCT_FULL));
    assign hi_r    = PIX_W'(((32'(roi_e_r) * NPIX) / 32'(PCT_FULL)) - 1);
    assign above   = vid_data > thr_lvl;
    // First sample of a line is pixel zero, not the stale count
    assign pix_idx = vid_first ? PIX_W'(0) : pix_r;
    assign in_roi  = pix_idx >= lo_r && pix_idx <= hi_r;
    assign split   = dip_r <= VID_W'((32'(pk_max_r) * (32'(PCT_FULL) - 32'(mod_r))) / 32'(PCT_FULL))
                     && vid_data > dip_r && pk_max_r != '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pk_st_r    <= PK_IDLE;
            pix_r      <= '0;
            pk_max_r   <= '0;
            dip_r      <= '0;
            sum_w_r    <= 48'h0;
            sum_r      <= 32'h0000_0000;
            last_max_r <= '0;
            line_max_r <= '0;
            meas_valid <= 1'b0;
            meas_pos   <= 32'h0000_0000;
        end else begin
            meas_valid <= 1'b0;
            if (vid_valid) begin
                pix_r <= pix_idx + PIX_W'(1);
                if (vid_first || vid_data > line_max_r) begin
                    line_max_r <= vid_data;
                end
                case (pk_st_r)
                    PK_IDLE: if (above && cyc_trig_r) begin
                        pk_st_r  <= in_roi ? PK_IN : PK_DROP;
                        pk_max_r <= vid_data;
                        dip_r    <= vid_data;
                        sum_w_r  <= 48'(vid_data) * 48'(pix_idx);
                        sum_r    <= 32'(vid_data);
                    end
                    PK_IN: if (!above || vid_last || split) begin
                        pk_st_r <= PK_DONE;
                        if (!split) begin
                            pk_st_r <= PK_IDLE;
                        end
                        meas_valid <= sum_r != 0;
                        meas_pos   <= 32'(sum_w_r / 48'(sum_r));
                        pk_max_r   <= vid_data;
                        dip_r      <= vid_data;
                        sum_w_r    <= 48'(vid_data) * 48'(pix_idx);
                        sum_r      <= 32'(vid_data);
                        if (split) begin
                            pk_st_r <= PK_IN;
                        end
                    end else if (!in_roi) begin
                        pk_st_r <= PK_DROP;
                    end else begin
                        pk_max_r <= (vid_data > pk_max_r) ? vid_data : pk_max_r;
                        dip_r    <= (vid_data > pk_max_r) ? vid_data :
                                    (vid_data < dip_r) ? vid_data : dip_r;
                        sum_w_r  <= sum_w_r + 48'(vid_data) * 48'(pix_idx);
                        sum_r    <= sum_r + 32'(vid_data);
                    end
                    PK_DROP: if (!above || vid_last) begin
                        pk_st_r <= PK_IDLE;
                    end
                    default: pk_st_r <= PK_IDLE;
                endcase
                if (vid_last) begin
                    // Held over the cycle boundary so exposure control sees the whole line
                    last_max_r <= (vid_first || vid_data > line_max_r) ? vid_data : line_max_r;
                    if (pk_st_r != PK_IN) begin
                        pk_st_r <= PK_IDLE;
                    end
                end
            end
        end
    end

    // Output counter; only triggered results reach averaging, so stale
    // pre-trigger values never enter the mean
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meas_cnt <= 32'h0000_0000;
        end else if (cnt_clr) begin
            meas_cnt <= 32'h0000_0000;
        end else if (meas_valid) begin
            meas_cnt <= meas_cnt + 32'h0000_0001;
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'h0;
                if (s_axi_araddr == ADDR_CTRL) begin
                    s_axi_rdata <= {29'h0, trig_en_r, mode_r};
                end else if (s_axi_araddr == ADDR_PERIOD) begin
                    s_axi_rdata <= period_r;
                end else if (s_axi_araddr == ADDR_EXP1) begin
                    s_axi_rdata <= {18'h0, exp1_r};
                end else if (s_axi_araddr == ADDR_EXP2) begin
                    s_axi_rdata <= {18'h0, exp2_r};
                end else if (s_axi_araddr == ADDR_ROI) begin
                    s_axi_rdata <= {17'h0, roi_e_r, 1'b0, roi_s_r};
                end else if (s_axi_araddr == ADDR_THR) begin
                    s_axi_rdata <= {17'h0, mod_r, 1'b0, thr_r};
                end else if (s_axi_araddr == ADDR_STAT) begin
                    s_axi_rdata <= {24'h0, ttd_v_r[TTD_LAT-1], settle_r, bad_cfg_r};
                end else if (s_axi_araddr == ADDR_CNT) begin
                    s_axi_rdata <= meas_cnt;
                end else if (s_axi_araddr == ADDR_TTD) begin
                    s_axi_rdata <= ttd_pipe_r[TTD_LAT-1];
                end else if (s_axi_araddr == ADDR_TSTAMP) begin
                    s_axi_rdata <= tstamp_r;
                end else if (s_axi_araddr == ADDR_EXPCUR) begin
                    s_axi_rdata <= {18'h0, expo_time};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_expo_end_time: assert property (cycle_start |-> ##(EXP_END_CYC) expo_end)
        else $error("exposure end not at fixed offset");
    a_alt_swap: assert property (cycle_start && mode_r == MODE_ALT && $stable(mode_r) && $past(mode_r) == MODE_ALT
        && $past(cycle_start) == 0 |-> expo_time != $past(expo_time, 2) || exp1_r == exp2_r)
        else $error("alternating exposure did not swap");
    a_manual_hold: assert property (mode_r == MODE_MAN && $past(mode_r) == MODE_MAN && $stable(exp1_r)
        && !cycle_start |-> $stable(expo_time))
        else $error("manual exposure changed");
    a_exp_order: assert property (exp2_r < exp1_r)
        else $error("second exposure not below primary");
    a_exp_range: assert property (exp1_r >= 14'(EXP_MIN_US) && exp1_r <= 14'(EXP_MAX_US))
        else $error("primary exposure out of range");
    a_bypass_alt: assert property (mode_r == MODE_ALT |=> avg_bypass || $past(mode_r) != MODE_ALT)
        else $error("averaging not bypassed");
    a_cnt_step: assert property (meas_valid && !cnt_clr |=> meas_cnt == $past(meas_cnt) + 32'h0000_0001)
        else $error("counter did not step");
    a_cnt_clear: assert property (cnt_clr |=> meas_cnt == 32'h0000_0000)
        else $error("counter not cleared");
    a_untrig_quiet: assert property (!cyc_trig_r && pk_st_r == PK_IDLE |=> pk_st_r == PK_IDLE)
        else $error("peak started without trigger");
    a_reg_range: assert property (mode_r == MODE_REG |-> expo_time >= 14'(EXP_MIN_US) && expo_time <= 14'(EXP_MAX_US))
        else $error("regulated exposure out of range");
    c_trig_meas: cover property (cyc_trig_r && meas_valid);
    c_split: cover property (pk_st_r == PK_IN && split && vid_valid);
    c_drop: cover property (pk_st_r == PK_DROP);
endmodule // tpa_acq

// ### hw/tpa_pkg.sv
// Package for the triggered peak acquisition block
// Assumes a 100 MHz aclk and an AXI4-Lite register master
package tpa_pkg;
    localparam int          CLK_NS          = 10;
    localparam int          EXP_END_NS      = 100;
    localparam int          EXP_END_CYC     = (EXP_END_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TTD_LAT         = 3;
    localparam int          SETTLE_MAX      = 7;
    localparam int          EXP_MIN_US      = 3;
    localparam int          EXP_MAX_US      = 10000;
    localparam int          CYC_PER_US      = 1000 / CLK_NS;
    localparam int          TRIG_MIN_NS     = 5000;
    localparam int          TRIG_MIN_CYC    = TRIG_MIN_NS / CLK_NS;
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_PERIOD     = 8'h04;
    localparam logic [7:0]  ADDR_EXP1       = 8'h08;
    localparam logic [7:0]  ADDR_EXP2       = 8'h0C;
    localparam logic [7:0]  ADDR_ROI        = 8'h10;
    localparam logic [7:0]  ADDR_THR        = 8'h14;
    localparam logic [7:0]  ADDR_STAT       = 8'h18;
    localparam logic [7:0]  ADDR_CNT        = 8'h1C;
    localparam logic [7:0]  ADDR_TTD        = 8'h20;
    localparam logic [7:0]  ADDR_TSTAMP     = 8'h24;
    localparam logic [7:0]  ADDR_EXPCUR     = 8'h28;
    localparam int          CTRL_MODE_LSB   = 0;
    localparam int          CTRL_TRIGEN     = 2;
    localparam int          CTRL_CNTCLR     = 3;
    localparam int          CTRL_TSCLR      = 4;
    localparam logic [31:0] PERIOD_RST      = 32'h0000_2710;
    localparam logic [13:0] EXP1_RST        = 14'h0064;
    localparam logic [13:0] EXP2_RST        = 14'h0032;
    localparam logic [6:0]  ROI_START_RST   = 7'h00;
    localparam logic [6:0]  ROI_END_RST     = 7'h64;
    localparam logic [6:0]  MOD_RST         = 7'h32;
    localparam logic [6:0]  THR_RST         = 7'h02;
    localparam logic [6:0]  PCT_FULL        = 7'h64;
    typedef enum logic [1:0] {
        MODE_REG  = 2'h0,
        MODE_MAN  = 2'h1,
        MODE_ALT  = 2'h2,
        MODE_AUTO = 2'h3
    } tpa_mode_t;
    typedef enum logic [3:0] {
        PK_IDLE = 4'b0001,
        PK_IN   = 4'b0010,
        PK_DROP = 4'b0100,
        PK_DONE = 4'b1000
    } tpa_pk_t;
endpackage

// ### tb/testbench.sv
// Bench for tpa_acq: AXI4-Lite master, trigger source, result count model
// Assumes tpa_vid_src sends one 16-pixel line per exposure end
`timescale 1ns/1ps
module testbench;
    import tpa_pkg::*;
    logic aclk = 0, aresetn = 0, trig_in = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, vid_valid, vid_first, vid_last, cycle_start, expo_end;
    logic meas_valid, avg_bypass, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [11:0] vid_data, amp = 12'h0800;
    logic [13:0] expo_time, e1, ea;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, meas_pos, meas_cnt, rd;
    int fail_count = 0, check_count = 0, n = 0;
    tpa_acq tpa_acq_i (.aclk, .aresetn, .trig_in, .vid_valid, .vid_data, .vid_first, .vid_last, .cycle_start,
        .expo_end, .expo_time, .meas_valid, .meas_pos, .meas_cnt, .avg_bypass, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    tpa_vid_src tpa_vid_src_i (.aclk, .expo_end, .amp, .vid_valid, .vid_data, .vid_first, .vid_last);
    initial forever #5 aclk = ~aclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Each channel is released only at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic ar(input logic [7:0] a);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_arvalid || !s_axi_rvalid);
        {rd, rr} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        ar(a);
        chk(rd, e);
    endtask
    always @(posedge aclk) if (meas_valid === 1'b1) begin
        n = n + 1;
        chk(meas_pos, 32'h0000_0008);
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        give_verdict;
    end
    initial begin
        void'($urandom(32'h57d0_19f6));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rc(ADDR_PERIOD, PERIOD_RST);
        rc(ADDR_ROI, {ROI_END_RST, 1'b0, ROI_START_RST});
        rc(ADDR_THR, {MOD_RST, 1'b0, THR_RST});
        wr(ADDR_EXP1, 32'h0000_0002);
        rc(ADDR_EXP1, EXP1_RST);
        wr(ADDR_EXP2, 32'h0000_00c8);
        rc(ADDR_EXP2, EXP2_RST);
        e1 = 14'(51 + $urandom % (EXP_MAX_US - 50));
        wr(ADDR_EXP1, e1);
        rc(ADDR_EXP1, e1);
        wr(ADDR_PERIOD, 32'h0000_0040);
        wr(ADDR_CTRL, 32'h0000_0005);
        amp <= 12'h0400 + 12'($urandom % 3072);
        repeat (200) @(posedge aclk);
        chk(n, 0);
        chk(expo_time, e1);
        // Pulses held 500 clocks, the shortest legal edge trigger
        repeat (2) begin
            repeat ($urandom % 64) @(posedge aclk);
            trig_in <= 1'b1;
            repeat (500) @(posedge aclk);
            trig_in <= 1'b0;
            repeat (200) @(posedge aclk);
        end
        chk(n, 2);
        chk(meas_cnt, 2);
        wr(ADDR_CTRL, 32'h0000_000d);
        repeat (3) @(posedge aclk);
        chk(meas_cnt, 0);
        wr(ADDR_CTRL, 32'h0000_0006);
        repeat (2) @(posedge cycle_start);
        repeat (20) @(posedge aclk);
        ea = expo_time;
        @(posedge cycle_start);
        repeat (20) @(posedge aclk);
        chk(ea ^ expo_time, e1 ^ EXP2_RST);
        chk(avg_bypass, 1);
        wr(ADDR_CTRL, 32'h0000_0007);
        repeat (2) begin
            repeat (2) @(posedge cycle_start);
            repeat (20) @(posedge aclk);
            chk(expo_time, amp[11] ? EXP2_RST : e1);
            amp <= amp ^ 12'h0800;
        end
        wr(ADDR_CTRL, 32'h0000_0004);
        amp <= 12'h0fff;
        repeat (2) @(posedge cycle_start);
        repeat (20) @(posedge aclk);
        ea = expo_time;
        @(posedge cycle_start);
        repeat (20) @(posedge aclk);
        chk(expo_time, ((ea >> 1) < 14'(EXP_MIN_US)) ? 14'(EXP_MIN_US) : ea >> 1);
        ar(8'h2c);
        chk(rr, 2);
        give_verdict;
    end
endmodule // testbench

// ### tb/tpa_vid_src.sv
// Line detector stand-in: one symmetric peak per exposure end
// Assumes expo_end pulses once per cycle; amp sets the peak height
`timescale 1ns/1ps
module tpa_vid_src (
    input  wire logic        aclk,
    input  wire logic        expo_end,
    input  wire logic [11:0] amp,
    output logic             vid_valid = 1'b0,
    output logic [11:0]      vid_data  = 12'h000,
    output logic             vid_first = 1'b0,
    output logic             vid_last  = 1'b0
);
    int pix = -1;
    // Idle data inverts so a stale pixel never passes for a fresh one
    always @(posedge aclk) begin
        pix <= expo_end ? 0 : (pix == 15 || pix < 0) ? -1 : pix + 1;
        vid_valid <= pix >= 0;
        vid_first <= pix == 0;
        vid_last <= pix == 15;
        vid_data <= pix < 0 ? ~vid_data : (pix > 5 && pix < 11) ? amp >> ((pix > 8) ? pix - 8 : 8 - pix) : 12'h000;
    end
endmodule // tpa_vid_src
